// ==== verilog/cem_regs.svh ====
// Constants of the configuration CRC error monitor.
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
`ifndef CEM_REGS_SVH
`define CEM_REGS_SVH
`define CEM_OSC_MHZ 200
`define CEM_SYS_MHZ 200
`define CEM_EXP_MIN 4'h1
`define CEM_EXP_MAX 4'h8
`define CEM_GAP_CYCLES 6'h20
`define CEM_SYN_W 16
`define CEM_LOC_W 27
`define CEM_TYPE_W 3
`define CEM_SEARCH_CYCLES 6'h08
`endif

// ==== verilog/cem_pkg.sv ====
// Types of the configuration CRC error monitor.
`include "cem_regs.svh"
package cem_pkg;
	typedef enum logic [2:0] {
		CEM_IDLE = 3'b000,
		CEM_CHECK = 3'b001,
		CEM_SEARCH = 3'b010,
		CEM_REPORT = 3'b011,
		CEM_HIGH = 3'b100,
		CEM_GAP = 3'b101
	} cem_state_t;
	typedef struct packed {
		logic [`CEM_TYPE_W-1:0] err_type;
		logic [`CEM_LOC_W-1:0] location;
		logic [`CEM_SYN_W-1:0] syndrome;
	} cem_report_t;
	typedef struct packed {
		logic valid;
		logic [`CEM_SYN_W-1:0] syndrome;
		logic [`CEM_TYPE_W-1:0] err_type;
		logic [`CEM_LOC_W-1:0] location;
	} cem_frame_t;
	typedef struct packed {
		cem_state_t st;
		logic [7:0] div_cnt;
		logic tick;
		logic [5:0] cnt;
		logic [`CEM_SYN_W-1:0] syn;
		cem_report_t report;
		cem_report_t pend;
		logic rep_valid;
		cem_report_t upd;
		logic upd_valid;
		logic flag;
		logic pin_flag;
		logic [2:0] um_sync;
		logic running;
		logic [31:0] frames;
	} cem_state_all_t;
endpackage : cem_pkg

// ==== verilog/cem_monitor.sv ====
// Configuration CRC error monitor: divider, frame pacing, report and flag.
`timescale 1ns/1ps
`default_nettype none
`include "cem_regs.svh"
module cem_monitor #(
	parameter logic [3:0] DIV_EXP = 4'h1
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic monitor_enable,
	input wire logic user_mode,
	input wire cem_pkg::cem_frame_t frame_result,
	output logic frame_strobe,
	output cem_pkg::cem_report_t error_report_register,
	output cem_pkg::cem_report_t update_report,
	output logic update_valid,
	output logic error_flag,
	output logic error_flag_pin,
	output logic running
);
	import cem_pkg::*;

	cem_state_all_t s_q;
	cem_state_all_t s_d;
	logic [7:0] div_top;
	logic err_hit;

	//--------------------------------------------------------------------------
	// Divider and fault helpers
	//--------------------------------------------------------------------------
	// Clamps the exponent to its legal range and gives the terminal count.
	function automatic logic [7:0] cem_div_top(input logic [3:0] e);
		logic [3:0] x;
		x = e;
		if (x < `CEM_EXP_MIN)
			x = `CEM_EXP_MIN;
		if (x > `CEM_EXP_MAX)
			x = `CEM_EXP_MAX;
		cem_div_top = 8'((9'h001 << x) - 9'h001);
	endfunction : cem_div_top

	// A frame is faulty when it is valid and its syndrome is not zero.
	function automatic logic cem_is_fault(input cem_frame_t f);
		cem_is_fault = f.valid && (f.syndrome != '0);
	endfunction : cem_is_fault

	assign div_top = cem_div_top(DIV_EXP);
	assign err_hit = s_q.tick && cem_is_fault(frame_result);

	//--------------------------------------------------------------------------
	// Next state
	//--------------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.um_sync = {s_q.um_sync[1:0], user_mode};
		s_d.tick = 1'b0;
		s_d.upd_valid = 1'b0;
		// Monitor clock: the oscillator divided by two to the exponent.
		if (s_q.running) begin
			if (s_q.div_cnt == div_top) begin
				s_d.div_cnt = 8'h00;
				s_d.tick = 1'b1;
			end else begin
				s_d.div_cnt = 8'(s_q.div_cnt + 8'h01);
			end
		end
		// Start once user mode has settled; never stops until reset.
		if (monitor_enable && s_q.um_sync[2] && s_q.um_sync[1]) begin
			s_d.running = 1'b1;
		end
		// Latest error found overwrites any pending one.
		if (err_hit) begin
			s_d.syn = frame_result.syndrome;
			s_d.pend.syndrome = frame_result.syndrome;
			s_d.pend.location = frame_result.location;
			s_d.pend.err_type = frame_result.err_type;
		end
		if (s_q.tick && frame_result.valid)
			s_d.frames = 32'(s_q.frames + 32'h1);
		case (s_q.st)
			CEM_IDLE: begin
				if (s_q.running)
					s_d.st = CEM_CHECK;
			end
			CEM_CHECK: begin
				if (s_q.syn != '0) begin
					s_d.st = CEM_SEARCH;
					s_d.cnt = '0;
				end
			end
			CEM_SEARCH: begin
				if (s_q.tick)
					s_d.cnt = 6'(s_q.cnt + 6'h01);
				if (s_q.cnt == `CEM_SEARCH_CYCLES) begin
					s_d.st = CEM_REPORT;
				end
			end
			CEM_REPORT: begin
				s_d.report = s_q.pend;
				s_d.rep_valid = 1'b1;
				// A fault found in this very cycle must not be lost.
				if (!err_hit)
					s_d.syn = '0;
				s_d.st = CEM_HIGH;
			end
			CEM_HIGH: begin
				s_d.upd = s_q.report;
				s_d.upd_valid = 1'b1;
				s_d.flag = 1'b1;
				s_d.cnt = '0;
				s_d.st = CEM_GAP;
			end
			CEM_GAP: begin
				s_d.flag = 1'b0;
				if (s_q.tick)
					s_d.cnt = 6'(s_q.cnt + 6'h01);
				if (s_q.cnt == `CEM_GAP_CYCLES)
					s_d.st = CEM_CHECK;
			end
			default: s_d.st = CEM_IDLE;
		endcase
		s_d.pin_flag = monitor_enable & s_d.flag;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign frame_strobe = s_q.tick;
	assign error_report_register = s_q.report;
	assign update_report = s_q.upd;
	assign update_valid = s_q.upd_valid;
	assign error_flag = s_q.flag;
	assign error_flag_pin = s_q.pin_flag;
	assign running = s_q.running;

	//--------------------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------------------
	sequence s_rise;
		$rose(error_flag);
	endsequence

	property p_flag_one;
		@(posedge sys_clk) disable iff (reset)
		s_rise |=> !error_flag;
	endproperty
	a_flag_one: assert property (p_flag_one) else $error("flag high too long");

	property p_gap;
		@(posedge sys_clk) disable iff (reset)
		$fell(error_flag) |-> !error_flag [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("flag gap too short");

	property p_update_after;
		@(posedge sys_clk) disable iff (reset)
		s_rise |-> update_valid;
	endproperty
	a_update_after: assert property (p_update_after) else $error("no update");

	property p_report_first;
		@(posedge sys_clk) disable iff (reset)
		s_rise |-> update_report == error_report_register;
	endproperty
	a_report_first: assert property (p_report_first) else $error("stale report");

	property p_nonzero;
		@(posedge sys_clk) disable iff (reset)
		s_rise |-> error_report_register.syndrome != '0;
	endproperty
	a_nonzero: assert property (p_nonzero) else $error("zero syndrome");

	property p_run_sticky;
		@(posedge sys_clk) disable iff (reset)
		running |=> running;
	endproperty
	a_run_sticky: assert property (p_run_sticky) else $error("stopped");

	property p_pin;
		@(posedge sys_clk) disable iff (reset)
		$rose(error_flag) && monitor_enable |-> error_flag_pin;
	endproperty
	a_pin: assert property (p_pin) else $error("pin not driven");

	property p_tick_space;
		@(posedge sys_clk) disable iff (reset)
		frame_strobe |=> !frame_strobe;
	endproperty
	a_tick_space: assert property (p_tick_space) else $error("tick rate");

	//--------------------------------------------------------------------------
	// Report and flag sequencing checks
	//--------------------------------------------------------------------------
	sequence s_report_step;
		s_q.st == CEM_REPORT;
	endsequence

	sequence s_flag_step;
		##2 error_flag;
	endsequence

	sequence s_update_step;
		##2 (update_valid && update_report == error_report_register);
	endsequence

	property p_report_to_flag;
		@(posedge sys_clk) disable iff (reset)
		s_report_step |-> s_flag_step;
	endproperty
	a_report_to_flag: assert property (p_report_to_flag) else $error("no flag");

	property p_report_to_update;
		@(posedge sys_clk) disable iff (reset)
		s_report_step |-> s_update_step;
	endproperty
	a_report_to_update: assert property (p_report_to_update) else $error("upd late");

	property p_report_load;
		@(posedge sys_clk) disable iff (reset)
		$changed(error_report_register) |-> $past(s_q.st) == CEM_REPORT;
	endproperty
	a_report_load: assert property (p_report_load) else $error("stray load");

	property p_search_len;
		@(posedge sys_clk) disable iff (reset)
		s_q.st == CEM_SEARCH && s_d.st == CEM_REPORT
			|-> s_q.cnt == `CEM_SEARCH_CYCLES;
	endproperty
	a_search_len: assert property (p_search_len) else $error("short search");

	property p_gap_low;
		@(posedge sys_clk) disable iff (reset)
		s_q.st == CEM_GAP |=> !error_flag;
	endproperty
	a_gap_low: assert property (p_gap_low) else $error("flag in gap");

	property p_gap_len;
		@(posedge sys_clk) disable iff (reset)
		s_q.st == CEM_GAP && s_d.st != CEM_GAP
			|-> s_q.cnt == `CEM_GAP_CYCLES;
	endproperty
	a_gap_len: assert property (p_gap_len) else $error("short gap");

	property p_flag_src;
		@(posedge sys_clk) disable iff (reset)
		$rose(error_flag) |-> $past(s_q.st) == CEM_HIGH;
	endproperty
	a_flag_src: assert property (p_flag_src) else $error("flag source");

	property p_upd_pulse;
		@(posedge sys_clk) disable iff (reset)
		update_valid |=> !update_valid;
	endproperty
	a_upd_pulse: assert property (p_upd_pulse) else $error("upd too long");

	//--------------------------------------------------------------------------
	// Start, pacing, capture and pin checks
	//--------------------------------------------------------------------------
	property p_start;
		@(posedge sys_clk) disable iff (reset)
		$rose(running) |-> $past(s_q.um_sync[2]) && $past(s_q.um_sync[1]);
	endproperty
	a_start: assert property (p_start) else $error("early start");

	property p_idle_quiet;
		@(posedge sys_clk) disable iff (reset)
		!running |-> !frame_strobe && !error_flag;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle active");

	property p_div_range;
		@(posedge sys_clk) disable iff (reset)
		s_q.div_cnt <= div_top;
	endproperty
	a_div_range: assert property (p_div_range) else $error("div overrun");

	property p_div_wrap;
		@(posedge sys_clk) disable iff (reset)
		running && s_q.div_cnt == div_top |=> frame_strobe;
	endproperty
	a_div_wrap: assert property (p_div_wrap) else $error("no tick");

	property p_capture;
		@(posedge sys_clk) disable iff (reset)
		err_hit |=> s_q.pend.syndrome == $past(frame_result.syndrome)
			&& s_q.syn != '0;
	endproperty
	a_capture: assert property (p_capture) else $error("lost fault");

	property p_frame_count;
		@(posedge sys_clk) disable iff (reset)
		frame_strobe && frame_result.valid
			|=> s_q.frames != $past(s_q.frames);
	endproperty
	a_frame_count: assert property (p_frame_count) else $error("frame skip");

	property p_pin_off;
		@(posedge sys_clk) disable iff (reset)
		!monitor_enable |=> !error_flag_pin;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin driven");

	property p_pin_follow;
		@(posedge sys_clk) disable iff (reset)
		error_flag_pin |-> error_flag;
	endproperty
	a_pin_follow: assert property (p_pin_follow) else $error("pin stray");
endmodule : cem_monitor
`default_nettype wire

// ==== verification/cem_sys_model.sv ====
// Far-side system model: frame source and error report reader.
`timescale 1ns/1ps
`default_nettype none
module cem_sys_model (
	input wire logic sys_clk,
	input wire logic inject,
	input wire cem_pkg::cem_frame_t inj_frame,
	input wire logic error_flag,
	input wire cem_pkg::cem_report_t error_report_register,
	output cem_pkg::cem_frame_t frame_result,
	output cem_pkg::cem_report_t got_report,
	output logic reconfig_request_n
);
	import cem_pkg::*;
	logic flag_q = 1'b0;
	assign frame_result = inject ? inj_frame : cem_frame_t'{1'b1, '0, '0, '0};
	always_ff @(posedge sys_clk) begin
		flag_q <= error_flag;
		reconfig_request_n <= 1'b1;
		if (error_flag && !flag_q) begin
			got_report <= error_report_register;
			reconfig_request_n <= 1'b0;
		end
	end
endmodule : cem_sys_model
`default_nettype wire

// ==== verification/tb_cem_monitor.sv ====
// Self-checking bench of the configuration CRC error monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_cem_monitor;
	import cem_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic monitor_enable = 1'b1;
	logic user_mode = 1'b0;
	logic inject = 1'b0;
	cem_frame_t inj_frame = '0;
	cem_frame_t frame_result;
	cem_report_t error_report_register, update_report, got_report;
	logic frame_strobe, update_valid, error_flag, error_flag_pin;
	logic running, reconfig_request_n;
	int error_cnt = 0;
	int compares = 0;
	int strobe_cnt = 0;
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (frame_strobe === 1'b1) strobe_cnt++;
	cem_monitor #(.DIV_EXP(4'h1)) u_dut (.sys_clk(sys_clk), .reset(reset),
		.monitor_enable(monitor_enable), .user_mode(user_mode),
		.frame_result(frame_result), .frame_strobe(frame_strobe),
		.error_report_register(error_report_register),
		.update_report(update_report), .update_valid(update_valid),
		.error_flag(error_flag), .error_flag_pin(error_flag_pin),
		.running(running));
	cem_sys_model u_sys (.sys_clk(sys_clk), .inject(inject),
		.inj_frame(inj_frame), .error_flag(error_flag),
		.error_report_register(error_report_register),
		.frame_result(frame_result), .got_report(got_report),
		.reconfig_request_n(reconfig_request_n));
	task automatic close_out();
		$display("Compares %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	task automatic check(string what, logic [45:0] seen, logic [45:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic timeout(string what);
		error_cnt++;
		$display("[FAIL] %s expected event seen timeout", what);
		close_out();
	endtask : timeout
	task automatic wait_sig(ref logic s, input string what);
		for (int i = 0; i < 400; i++) begin
			@(negedge sys_clk);
			if (s === 1'b1) return;
		end
		timeout(what);
	endtask : wait_sig
	task automatic send(cem_frame_t f);
		@(posedge sys_clk);
		inj_frame <= f;
		inject <= 1'b1;
		wait_sig(frame_strobe, "strobe");
		@(posedge sys_clk);
		inject <= 1'b0;
	endtask : send
	function automatic cem_report_t rep(cem_frame_t f);
		return {f.err_type, f.location, f.syndrome};
	endfunction : rep
	task automatic t_start();
		int t;
		repeat (6) @(negedge sys_clk);
		check("idle strobe", 46'(strobe_cnt), 46'h0);
		@(posedge sys_clk);
		user_mode <= 1'b1;
		wait_sig(running, "running");
		wait_sig(frame_strobe, "strobe");
		t = strobe_cnt;
		repeat (4) @(negedge sys_clk);
		check("pace", 46'(strobe_cnt - t), 46'h2);
		$display("Test start done");
	endtask : t_start
	task automatic t_single();
		cem_frame_t f = '{1'b1, 16'h1234, 3'h5, 27'h0ABCDEF};
		send(f);
		wait_sig(error_flag, "flag");
		check("report", error_report_register, rep(f));
		check("pin", 46'(error_flag_pin), 46'h1);
		check("upd valid", 46'(update_valid), 46'h1);
		check("upd report", update_report, rep(f));
		@(negedge sys_clk);
		check("reader", got_report, rep(f));
		check("reconfig", 46'(reconfig_request_n), 46'h0);
		$display("Test single done");
	endtask : t_single
	task automatic t_back();
		cem_frame_t f2 = '{1'b1, 16'h00FF, 3'h2, 27'h7000001};
		cem_frame_t f3 = '{1'b1, 16'h8001, 3'h1, 27'h0000010};
		int s0;
		send(f2);
		send(f3);
		wait_sig(error_flag, "flag");
		check("overwrite", error_report_register, rep(f3));
		s0 = strobe_cnt;
		send(f2);
		wait_sig(error_flag, "flag");
		check("gap", 46'(strobe_cnt - s0 >= 32), 46'h1);
		check("again", error_report_register, rep(f2));
		check("running", 46'(running), 46'h1);
		$display("Test back done");
	endtask : t_back
	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		t_start();
		t_single();
		t_back();
		close_out();
	end
endmodule : tb_cem_monitor
`default_nettype wire
